// ---- core/tefru_core.sv ----
// Event flags, request enables and software event generation of a timer
//
// Functional notes
// - DMA enables at bits 14..8 gate trigger, COM, channel 4..1, update DMA requests.
// - Interrupt enables at bits 7..0 gate break, trigger, COM, channels, update.
// - Reserved bits of enable, status and generation registers read as zero.
// - Input channel capture while its flag is set raises the overcapture flag.
// - Break flag sets on active break; write-zero clears only when break inactive.
// - Trigger edge sets trigger flag when slave mode enabled and not gated.
// - Transfer of preloaded channel control bits sets the COM flag.
// - Output channel compare match, or wrap when compare exceeds reload, sets flag.
// - Input capture sets channel flag; write-zero or capture register read clears it.
// - Channels 2 to 4 flags behave like channel 1 for their own channel.
// - Counter wrap with repetition zero sets update flag unless update disabled.
// - Software or slave reinit sets update flag only if source and disable clear.
// - Generation bits are set by software and clear themselves after the event.
// - Break generation clears main output enable and sets the break flag.
// - Trigger generation sets the trigger flag with its requests.
// - COM generation with preload control loads the channel control bits.
// - Channel generation on output channel sets its flag and requests.
// - Channel generation on input captures counter, sets flag, maybe overcapture.
// - Generation bits 2 to 4 act on channels 2 to 4 like channel 1.
// - Update generation reinits counter, updates preloads, clears prescaler.
// - Channel DMA select picks channel event or update event for channel DMA.
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/100ps
`default_nettype none

module tefru_core
	import tefru_pkg::*;
#(
	parameter int NCH = 4
) (
	input  wire logic        mclk,
	input  wire logic        reset,
	input  wire logic [7:0]  addr,
	input  wire logic [15:0] wdata,
	input  wire logic        wr_en,
	input  wire logic        rd_en,
	output logic      [15:0] rdata,
	input  wire tefru_evt_t  evt,
	output tefru_act_t       act,
	output logic             irq,
	output logic      [6:0]  dma_req
);

	// ==========================================
	// Helpers
	function automatic logic [15:0] tefru_mask(input logic [15:0] v, input logic [15:0] m);
		return v & m;
	endfunction

	// ==========================================
	// State
	logic [15:0]      enable_q;
	logic [15:0]      status_q;
	logic [15:0]      status_d;
	logic [15:0]      ctrl_q;
	logic [7:0]       gen_q;
	logic [7:0]       gen_d;
	logic [15:0]      rdata_q;
	logic [15:0]      rdata_d;
	logic             irq_q;
	logic [6:0]       dma_q;
	logic [6:0]       dma_d;
	tefru_act_t       act_q;
	tefru_act_t       act_d;
	tefru_gen_state_t gstate_q;
	tefru_gen_state_t gstate_d;
	logic             brk_s1_q;
	logic             brk_s2_q;

	// ==========================================
	// Decode
	wire wr_enable = wr_en && (addr == TEFRU_OFS_ENABLE);
	wire wr_status = wr_en && (addr == TEFRU_OFS_STATUS);
	wire wr_gen    = wr_en && (addr == TEFRU_OFS_GEN);
	wire wr_ctrl   = wr_en && (addr == TEFRU_OFS_CTRL);
	wire rd_hit_en = rd_en && (addr == TEFRU_OFS_ENABLE);
	wire rd_hit_st = rd_en && (addr == TEFRU_OFS_STATUS);
	wire rd_hit_ct = rd_en && (addr == TEFRU_OFS_CTRL);
	wire rd_hit_gn = rd_en && (addr == TEFRU_OFS_GEN);
	wire [15:0] enable_d = wr_enable ? tefru_mask(wdata, TEFRU_MASK_ENABLE) : enable_q;

	wire fire      = (gstate_q == TEFRU_GEN_FIRE);
	wire g_upd     = fire && gen_q[TEFRU_BIT_UPD];
	wire g_com     = fire && gen_q[TEFRU_BIT_COM];
	wire g_trg     = fire && gen_q[TEFRU_BIT_TRG];
	wire g_brk     = fire && gen_q[TEFRU_BIT_BRK];
	wire [3:0] g_ch = fire ? gen_q[TEFRU_BIT_CH1 +: 4] : 4'h0;

	wire update_request_source       = ctrl_q[TEFRU_CTL_URS];
	wire update_disable      = ctrl_q[TEFRU_CTL_UPDATE_DISABLE];
	wire preload   = ctrl_q[TEFRU_CTL_PRELOAD];
	wire dmasel    = ctrl_q[TEFRU_CTL_DMASEL];

	// Break pin is asynchronous to mclk
	wire brk_act   = brk_s2_q;

	// ==========================================
	// Set events
	wire ev_upd = (evt.cnt_wrap && evt.rep_zero && !update_disable)
	            || ((g_upd || evt.slave_reinit) && !update_request_source && !update_disable);
	wire ev_trg = (evt.trigger_edge && evt.slave_en && !evt.slave_gated)
	            || g_trg;
	wire ev_com = evt.ctrl_transfer || (g_com && preload);
	wire ev_brk = brk_act || g_brk;
	// Match strobe already covers wrap when compare exceeds reload
	wire [3:0] ev_out = (evt.chan_match & ~evt.chan_is_input)
	                  | (g_ch & ~evt.chan_is_input);
	wire [3:0] ev_in  = (evt.chan_capture | g_ch) & evt.chan_is_input;
	wire [3:0] ev_ch  = ev_out | ev_in;
	wire [3:0] ev_ovc = ev_in & status_q[TEFRU_BIT_CH1 +: 4];

	wire [15:0] set_vec = {3'b000, ev_ovc, 1'b0, ev_brk, ev_trg, ev_com, ev_ch, ev_upd};

	// Write-zero clear; break stays while input active
	wire [15:0] clr_wr  = wr_status ? ~wdata : 16'h0000;
	wire [15:0] clr_vec = {clr_wr[15:8], clr_wr[7] & ~brk_act, clr_wr[6:5],
	                       clr_wr[4:1] | (evt.chan_reg_read & evt.chan_is_input),
	                       clr_wr[0]};

	// Set wins over clear
	assign status_d = tefru_mask((status_q & ~clr_vec) | set_vec, TEFRU_MASK_STATUS);

	// ==========================================
	// Requests
	wire [3:0] ch_dma_ev = dmasel ? {NCH{ev_upd}} : ev_ch;
	assign dma_d = {ev_trg, ev_com, ch_dma_ev, ev_upd}
	             & enable_q[TEFRU_BIT_DMA0 +: 7];
	// Next flags and next enables, so irq never lags an enable write by a cycle
	wire irq_d = |(status_d[7:0] & enable_d[7:0]);

	// ==========================================
	// Generation sequencing: one cycle fire, then bits self-clear
	always_comb begin
		gstate_d = gstate_q;
		gen_d    = gen_q;
		case (gstate_q)
			TEFRU_GEN_IDLE: begin
				if (wr_gen && (wdata[7:0] != 8'h00)) begin
					gen_d    = wdata[7:0];
					gstate_d = TEFRU_GEN_FIRE;
				end
			end
			TEFRU_GEN_FIRE: begin
				gen_d    = 8'h00;
				gstate_d = TEFRU_GEN_IDLE;
			end
			default: begin
				gen_d    = 8'h00;
				gstate_d = TEFRU_GEN_IDLE;
			end
		endcase
	end

	always_comb begin
		act_d                 = '0;
		act_d.counter_reinit  = g_upd;
		act_d.count_down      = ctrl_q[TEFRU_CTL_DIR];
		act_d.prescaler_clear = g_upd;
		act_d.preload_update  = g_upd;
		act_d.ctrl_load       = g_com && preload;
		act_d.moe_clear       = g_brk;
		act_d.sw_capture      = g_ch & evt.chan_is_input;
	end

	// Reserved bits read zero; generation register reads zero
	assign rdata_d = rd_hit_en ? tefru_mask(enable_q, TEFRU_MASK_ENABLE) :
	                 rd_hit_st ? status_q :
	                 rd_hit_ct ? tefru_mask(ctrl_q, TEFRU_MASK_CTRL) : 16'h0000;

	// ==========================================
	// Registers
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			brk_s1_q <= 1'b0;
			brk_s2_q <= 1'b0;
		end else begin
			brk_s1_q <= evt.break_active;
			brk_s2_q <= brk_s1_q;
		end
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			enable_q <= TEFRU_RST_ENABLE;
			ctrl_q   <= TEFRU_RST_CTRL;
			status_q <= TEFRU_RST_STATUS;
		end else begin
			enable_q <= enable_d;
			if (wr_ctrl)
				ctrl_q <= tefru_mask(wdata, TEFRU_MASK_CTRL);
			status_q <= status_d;
		end
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			gen_q    <= 8'h00;
			gstate_q <= TEFRU_GEN_IDLE;
			act_q    <= '0;
			dma_q    <= 7'h00;
			irq_q    <= 1'b0;
			rdata_q  <= 16'h0000;
		end else begin
			gen_q    <= gen_d;
			gstate_q <= gstate_d;
			act_q    <= act_d;
			dma_q    <= dma_d;
			irq_q    <= irq_d;
			rdata_q  <= rdata_d;
		end
	end

	assign rdata   = rdata_q;
	assign act     = act_q;
	assign dma_req = dma_q;
	assign irq     = irq_q;

	// ==========================================
	// Checks
	AST_DMA_GATED: assert property (@(posedge mclk) disable iff (reset)
		!enable_q[TEFRU_BIT_DMA0] && !wr_enable |=> !dma_req[0])
		else $error("update DMA issued while disabled");

	AST_IRQ_FOLLOWS: assert property (@(posedge mclk) disable iff (reset)
		(|(status_q[7:0] & enable_q[7:0])) |-> irq)
		else $error("irq low with enabled pending flag");

	AST_RSVD_ZERO: assert property (@(posedge mclk) disable iff (reset)
		$past(rd_hit_st) |-> (rdata[15:13] == 3'b000) && !rdata[8])
		else $error("reserved status bits not zero");

	AST_OVERCAP: assert property (@(posedge mclk) disable iff (reset)
		ev_in[0] && status_q[TEFRU_BIT_CH1] |=> status_q[TEFRU_BIT_OVC1])
		else $error("overcapture not flagged");

	AST_BRK_HOLD: assert property (@(posedge mclk) disable iff (reset)
		brk_act |=> status_q[TEFRU_BIT_BRK])
		else $error("break flag lost while break active");

	AST_GEN_SELFCLR: assert property (@(posedge mclk) disable iff (reset)
		wr_gen && wdata[7:0] != 8'h00 && !fire |=> fire ##1 (gen_q == 8'h00))
		else $error("generation bits did not self-clear");

	AST_BRK_GEN: assert property (@(posedge mclk) disable iff (reset)
		g_brk |=> act.moe_clear && status_q[TEFRU_BIT_BRK])
		else $error("break generation incomplete");

	AST_UPD_GEN: assert property (@(posedge mclk) disable iff (reset)
		g_upd && (update_request_source || update_disable) && !evt.cnt_wrap && !evt.slave_reinit
		&& !status_q[TEFRU_BIT_UPD] |=> !status_q[TEFRU_BIT_UPD])
		else $error("update flag set against source or disable");

	AST_NO_SW_SET: assert property (@(posedge mclk) disable iff (reset)
		wr_status && !status_q[TEFRU_BIT_TRG] && !ev_trg |=> !status_q[TEFRU_BIT_TRG])
		else $error("software write set a flag");

	AST_CH_OUT_SET: assert property (@(posedge mclk) disable iff (reset)
		evt.chan_match[0] && !evt.chan_is_input[0] |=> status_q[TEFRU_BIT_CH1])
		else $error("compare match did not set channel flag");

	AST_CH_IN_SET: assert property (@(posedge mclk) disable iff (reset)
		evt.chan_capture[0] && evt.chan_is_input[0] |=> status_q[TEFRU_BIT_CH1])
		else $error("capture did not set channel flag");

	AST_CH_READ_CLR: assert property (@(posedge mclk) disable iff (reset)
		evt.chan_reg_read[0] && evt.chan_is_input[0] && !ev_ch[0] |=> !status_q[TEFRU_BIT_CH1])
		else $error("capture register read did not clear flag");

	AST_CH4_SET: assert property (@(posedge mclk) disable iff (reset)
		evt.chan_match[3] && !evt.chan_is_input[3] |=> status_q[TEFRU_BIT_CH1 + 3])
		else $error("channel 4 match did not set its flag");

	AST_TRG_SET: assert property (@(posedge mclk) disable iff (reset)
		evt.trigger_edge && evt.slave_en && !evt.slave_gated |=> status_q[TEFRU_BIT_TRG])
		else $error("trigger edge did not set trigger flag");

	AST_TRG_GATED: assert property (@(posedge mclk) disable iff (reset)
		evt.trigger_edge && evt.slave_gated && !g_trg && !status_q[TEFRU_BIT_TRG]
		|=> !status_q[TEFRU_BIT_TRG])
		else $error("trigger flag set in gated mode");

	AST_COM_SET: assert property (@(posedge mclk) disable iff (reset)
		evt.ctrl_transfer |=> status_q[TEFRU_BIT_COM])
		else $error("control transfer did not set COM flag");

	AST_COM_LOAD: assert property (@(posedge mclk) disable iff (reset)
		g_com && preload |=> act.ctrl_load)
		else $error("COM generation did not load control bits");

	AST_UPD_WRAP: assert property (@(posedge mclk) disable iff (reset)
		evt.cnt_wrap && evt.rep_zero && !update_disable |=> status_q[TEFRU_BIT_UPD])
		else $error("counter wrap did not set update flag");

	AST_UPD_RESET: assert property (@(posedge mclk) disable iff (reset)
		g_upd |=> act.counter_reinit && act.prescaler_clear && act.preload_update)
		else $error("update generation actions missing");

	AST_TRG_GEN: assert property (@(posedge mclk) disable iff (reset)
		g_trg |=> status_q[TEFRU_BIT_TRG])
		else $error("trigger generation did not set flag");

	AST_CH_GEN_OUT: assert property (@(posedge mclk) disable iff (reset)
		g_ch[0] && !evt.chan_is_input[0] |=> status_q[TEFRU_BIT_CH1])
		else $error("output channel generation did not set flag");

	AST_CH_GEN_IN: assert property (@(posedge mclk) disable iff (reset)
		g_ch[0] && evt.chan_is_input[0] |=> act.sw_capture[0] && status_q[TEFRU_BIT_CH1])
		else $error("input channel generation did not capture");

	AST_DMA_SEL: assert property (@(posedge mclk) disable iff (reset)
		dmasel && !ev_upd |=> (dma_req[4:1] == 4'h0))
		else $error("channel DMA issued without update event");

	AST_DMA_PULSE: assert property (@(posedge mclk) disable iff (reset)
		ev_trg && enable_q[TEFRU_BIT_DMA0 + 6] |=> dma_req[6])
		else $error("enabled trigger DMA request missing");

	AST_IRQ_OFF: assert property (@(posedge mclk) disable iff (reset)
		!(|(status_q[7:0] & enable_q[7:0])) |-> !irq)
		else $error("irq high without enabled pending flag");

	AST_RSVD_ENABLE: assert property (@(posedge mclk) disable iff (reset)
		$past(rd_hit_en) |-> !rdata[15])
		else $error("reserved enable bit not zero");

	AST_GEN_READ_ZERO: assert property (@(posedge mclk) disable iff (reset)
		$past(rd_hit_gn) |-> (rdata == 16'h0000))
		else $error("generation register read not zero");

	AST_BRK_CLR: assert property (@(posedge mclk) disable iff (reset)
		wr_status && !wdata[TEFRU_BIT_BRK] && !brk_act && !g_brk |=> !status_q[TEFRU_BIT_BRK])
		else $error("break flag not cleared while break inactive");

	AST_GEN_ONE_SHOT: assert property (@(posedge mclk) disable iff (reset)
		fire |=> !fire)
		else $error("generation fired for more than one cycle");

endmodule

`default_nettype wire

// ---- core/tefru_pkg.sv ----
// Package for the timer event flag and request unit
package tefru_pkg;

	// ==========================================
	// Register offsets
	localparam logic [7:0]  TEFRU_OFS_ENABLE = 8'h0C;
	localparam logic [7:0]  TEFRU_OFS_STATUS = 8'h10;
	localparam logic [7:0]  TEFRU_OFS_GEN    = 8'h14;
	localparam logic [7:0]  TEFRU_OFS_CTRL   = 8'h18;

	// ==========================================
	// Reset values and read masks
	localparam logic [15:0] TEFRU_RST_ENABLE = 16'h0000;
	localparam logic [15:0] TEFRU_RST_STATUS = 16'h0000;
	localparam logic [15:0] TEFRU_RST_CTRL   = 16'h0000;
	localparam logic [15:0] TEFRU_MASK_ENABLE = 16'h7FFF;
	localparam logic [15:0] TEFRU_MASK_STATUS = 16'h1EFF;
	localparam logic [15:0] TEFRU_MASK_CTRL   = 16'h001F;

	// ==========================================
	// Field positions
	localparam int TEFRU_BIT_UPD  = 0;
	localparam int TEFRU_BIT_CH1  = 1;
	localparam int TEFRU_BIT_COM  = 5;
	localparam int TEFRU_BIT_TRG  = 6;
	localparam int TEFRU_BIT_BRK  = 7;
	localparam int TEFRU_BIT_OVC1 = 9;
	localparam int TEFRU_BIT_DMA0 = 8;
	localparam int TEFRU_CTL_PRELOAD = 0;
	localparam int TEFRU_CTL_DMASEL  = 1;
	localparam int TEFRU_CTL_URS     = 2;
	localparam int TEFRU_CTL_UPDATE_DISABLE    = 3;
	localparam int TEFRU_CTL_DIR     = 4;

	// ==========================================
	// Event strobes from the rest of the timer
	typedef struct packed {
		logic       break_active;
		logic       trigger_edge;
		logic       slave_en;
		logic       slave_gated;
		logic       ctrl_transfer;
		logic       cnt_wrap;
		logic       rep_zero;
		logic       slave_reinit;
		logic [3:0] chan_is_input;
		logic [3:0] chan_match;
		logic [3:0] chan_capture;
		logic [3:0] chan_reg_read;
	} tefru_evt_t;

	// Actions pushed back into the timer
	typedef struct packed {
		logic       counter_reinit;
		logic       count_down;
		logic       prescaler_clear;
		logic       preload_update;
		logic       ctrl_load;
		logic       moe_clear;
		logic [3:0] sw_capture;
	} tefru_act_t;

	// ==========================================
	// Sequencing of a generation write
	typedef enum logic [1:0] {
		TEFRU_GEN_IDLE,
		TEFRU_GEN_FIRE
	} tefru_gen_state_t;

endpackage

// ---- dv/tefru_core_tb_top.sv ----
// Testbench for the timer event flag and request unit
`timescale 1ns/100ps
`default_nettype none

module tefru_core_tb_top;
	import tefru_pkg::*;
	logic        mclk = 1'b0;
	logic        reset = 1'b1;
	logic [7:0]  addr = 8'h00;
	logic [15:0] wdata = 16'h0000;
	logic        wr_en = 1'b0;
	logic        rd_en = 1'b0;
	logic [15:0] rdata;
	tefru_evt_t  evt = '0;
	tefru_act_t  act;
	logic        irq;
	logic [6:0]  dma_req;
	logic        seen_clr = 1'b0;
	logic [6:0]  dma_seen;
	logic        irq_seen;
	int          bad_count = 0;
	int          tests_run = 0;
	tefru_act_t  act_seen;

	always #2.5 mclk = ~mclk;

	tefru_core u_tefru_core (.mclk(mclk), .reset(reset), .addr(addr), .wdata(wdata), .wr_en(wr_en),
		.rd_en(rd_en), .rdata(rdata), .evt(evt), .act(act), .irq(irq), .dma_req(dma_req));
	tefru_host_model u_tefru_host_model (.mclk(mclk), .reset(reset), .irq(irq), .dma_req(dma_req),
		.seen_clr(seen_clr), .dma_seen(dma_seen), .irq_seen(irq_seen));

	// Sticky copy of the timer actions, since most stand one cycle only
	always_ff @(posedge mclk) begin
		if (reset || seen_clr)
			act_seen <= '0;
		else
			act_seen <= act_seen | act;
	end

	// ==========================================
	// Bus and check tasks
	task check(input string n, input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", n, exp, seen);
		end
	endtask
	task idle(input int n);
		repeat (n) @(posedge mclk);
	endtask
	task wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge mclk);
		addr <= a;
		wdata <= d;
		wr_en <= 1'b1;
		@(posedge mclk);
		wr_en <= 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [15:0] e);
		@(posedge mclk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge mclk);
		rd_en <= 1'b0;
		@(posedge mclk);
		check("rdata", rdata, e);
	endtask
	// Event pulses last one cycle; levels are set directly
	task pulse(input tefru_evt_t p);
		@(posedge mclk);
		evt <= evt | p;
		@(posedge mclk);
		evt <= evt & ~p;
		idle(2);
	endtask
	task gen(input logic [15:0] g);
		wr(TEFRU_OFS_GEN, g);
		idle(3);
	endtask
	task clr_all;
		wr(TEFRU_OFS_STATUS, 16'h0000);
		@(posedge mclk);
		seen_clr <= 1'b1;
		@(posedge mclk);
		seen_clr <= 1'b0;
		idle(1);
	endtask
	task close_out;
		$display("comparisons %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask

	// ==========================================
	// Tests
	initial begin
		tefru_evt_t p;
		idle(4);
		reset <= 1'b0;
		rd(TEFRU_OFS_ENABLE, 16'h0000);
		rd(TEFRU_OFS_GEN, 16'h0000);
		rd(8'h20, 16'h0000);
		wr(TEFRU_OFS_ENABLE, 16'hFFFF);
		rd(TEFRU_OFS_ENABLE, 16'h7FFF);
		wr(TEFRU_OFS_STATUS, 16'hFFFF);
		rd(TEFRU_OFS_STATUS, 16'h0000);
		gen(16'h005E);
		rd(TEFRU_OFS_STATUS, 16'h005E);
		rd(TEFRU_OFS_GEN, 16'h0000);
		check("dma", {9'h000, dma_seen}, 16'h005E);
		check("irq", {15'h0000, irq}, 16'h0001);
		check("act", {6'h00, act_seen}, 16'h0000);
		clr_all;
		check("irq", {15'h0000, irq}, 16'h0000);
		gen(16'h0080);
		rd(TEFRU_OFS_STATUS, 16'h0080);
		check("act", {6'h00, act_seen}, 16'h0010);
		clr_all;
		// Input capture on channel 1
		evt.chan_is_input <= 4'h1;
		p = '0;
		p.chan_capture = 4'h1;
		pulse(p);
		rd(TEFRU_OFS_STATUS, 16'h0002);
		pulse(p);
		rd(TEFRU_OFS_STATUS, 16'h0202);
		p = '0;
		p.chan_reg_read = 4'h1;
		pulse(p);
		rd(TEFRU_OFS_STATUS, 16'h0200);
		clr_all;
		gen(16'h0002);
		gen(16'h0002);
		rd(TEFRU_OFS_STATUS, 16'h0202);
		check("act", {6'h00, act_seen}, 16'h0001);
		clr_all;
		// Gated slave mode must not flag a trigger
		evt.slave_en <= 1'b1;
		evt.slave_gated <= 1'b1;
		p = '0;
		p.trigger_edge = 1'b1;
		pulse(p);
		rd(TEFRU_OFS_STATUS, 16'h0000);
		evt.slave_gated <= 1'b0;
		evt.chan_is_input <= 4'h0;
		p.ctrl_transfer = 1'b1;
		p.chan_match = 4'h8;
		pulse(p);
		rd(TEFRU_OFS_STATUS, 16'h0070);
		clr_all;
		// Update flag gating by disable and request source
		evt.rep_zero <= 1'b1;
		wr(TEFRU_OFS_CTRL, 16'h0008);
		p = '0;
		p.cnt_wrap = 1'b1;
		pulse(p);
		rd(TEFRU_OFS_STATUS, 16'h0000);
		wr(TEFRU_OFS_CTRL, 16'h0000);
		pulse(p);
		rd(TEFRU_OFS_STATUS, 16'h0001);
		clr_all;
		wr(TEFRU_OFS_CTRL, 16'h0004);
		gen(16'h0001);
		rd(TEFRU_OFS_STATUS, 16'h0000);
		check("act", {6'h00, act_seen}, 16'h02C0);
		clr_all;
		// COM generation loads control bits only with preload control set
		wr(TEFRU_OFS_CTRL, 16'h0010);
		gen(16'h0020);
		rd(TEFRU_OFS_STATUS, 16'h0000);
		wr(TEFRU_OFS_CTRL, 16'h0011);
		gen(16'h0020);
		rd(TEFRU_OFS_STATUS, 16'h0020);
		check("act", {6'h00, act_seen}, 16'h0120);
		clr_all;
		// Channel DMA moved onto the update event
		wr(TEFRU_OFS_CTRL, 16'h0002);
		p = '0;
		p.chan_match = 4'h1;
		pulse(p);
		check("dma", {9'h000, dma_seen}, 16'h0000);
		p = '0;
		p.cnt_wrap = 1'b1;
		pulse(p);
		check("dma", {9'h000, dma_seen}, 16'h001F);
		clr_all;
		// Break level holds its flag against a clear
		evt.break_active <= 1'b1;
		idle(5);
		wr(TEFRU_OFS_STATUS, 16'h0000);
		rd(TEFRU_OFS_STATUS, 16'h0080);
		check("irq_seen", {15'h0000, irq_seen}, 16'h0001);
		evt.break_active <= 1'b0;
		idle(5);
		wr(TEFRU_OFS_STATUS, 16'h0000);
		rd(TEFRU_OFS_STATUS, 16'h0000);
		// Cleared enables block requests
		clr_all;
		wr(TEFRU_OFS_ENABLE, 16'h3F3F);
		gen(16'h00C0);
		rd(TEFRU_OFS_STATUS, 16'h00C0);
		check("dma", {9'h000, dma_seen}, 16'h0000);
		check("irq", {15'h0000, irq}, 16'h0000);
		close_out;
	end

	// A hang ends the run after far more cycles than the tests need
	initial begin
		idle(5000);
		bad_count++;
		close_out;
	end
endmodule
`default_nettype wire

// ---- dv/tefru_host_model.sv ----
// Interrupt and DMA controller model seen from the timer unit
`timescale 1ns/100ps
`default_nettype none

module tefru_host_model (
	input  wire logic       mclk,
	input  wire logic       reset,
	input  wire logic       irq,
	input  wire logic [6:0] dma_req,
	input  wire logic       seen_clr,
	output logic      [6:0] dma_seen,
	output logic            irq_seen
);
	// ==========================================
	// Sticky capture, since a DMA request stands one cycle only
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			dma_seen <= 7'h00;
			irq_seen <= 1'b0;
		end else if (seen_clr) begin
			dma_seen <= 7'h00;
			irq_seen <= 1'b0;
		end else begin
			dma_seen <= dma_seen | dma_req;
			irq_seen <= irq_seen | irq;
		end
	end
endmodule
`default_nettype wire
